// [hw/serial_latch_device.sv]
// Purpose: converter front end: shift register, input register, latch, switch decode
// Assumes: link pins sampled on clock_in, link clock well below clock_in/2
// Notes: rst_in stands for the power-on reset
//
// Operation
// - sample data on rising serial clock, MSB first
// - word is sixteen clocks, registers sixteen bits
// - select high ignores clock and data
// - master drives select low, data on falling
// - rising select copies shift into input register
// - master raises select after sixteenth clock
// - extra clocks keep last sixteen bits
// - short select frame corrupts, master never sends one
// - low load strobe copies input to latch
// - pulsed master holds strobe high during frame
// - strobe tied low updates latch immediately
// - power-up sets input and latch mid-scale
// - shift register not cleared at power-up
// - short frame keeps older shift bits
// - master sends sixteen bits, all from the queued word
// - top four bits thermometer, twelve ladder
// - latch word is unsigned binary code
`timescale 1ns/100ps
`default_nettype none
module serial_latch_device
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // link
  serial_latch_if.device link,
  // converter controls
  output logic [serial_latch_pkg::WORD_W-1:0] latch_word_out,
  output logic [serial_latch_pkg::SEG_N-1:0] segment_switch_controls_out,
  output logic [serial_latch_pkg::LADDER_N-1:0] ladder_switch_controls_out,
  output logic word_taken_out
);
  import serial_latch_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************

  // thermometer code: n top-bit value turns on the n lowest segments
  function automatic logic [SEG_N-1:0] thermo(input logic [SEG_BITS-1:0] v);
    logic [SEG_N-1:0] t;
    t = '0;
    for (int i = 0; i < SEG_N; i++)
    begin
      t[i] = (i < int'(v));
    end
    return t;
  endfunction

  // low-to-high step between the older and the newer clean sample
  function automatic logic rising(input logic now_v, input logic before_v);
    return now_v && !before_v;
  endfunction

  // segment pattern that belongs to the mid-scale code held after reset
  localparam logic [SEG_N-1:0] SEG_AT_RESET = thermo(MID_SCALE[WORD_W-1 -: SEG_BITS]);

  // ************************************************************
  // pin synchronisers
  // ************************************************************

  // link pins come from another clock domain; their idle levels are high,
  // so resetting every stage high leaves no false edge after reset
  logic [2:0] s1_ff, s2_ff, s3_ff;
  logic sdi1_ff, sdi2_ff;
  logic sclk_s, sclk_d, sdi_s, cs_n_s, cs_n_d, ld_n_s;
  logic sclk_rise, cs_rise;

  // two-stage synchronisers; s3 gives edge history from the clean stage
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
    end
    else
    begin
      s1_ff <= {link.sclk, link.frame_sel_n, link.latch_load_n};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // data needs no reset: it is only read on a clean rise of the link clock
  always_ff @(posedge clock_in)
  begin
    sdi1_ff <= link.sdi;
    sdi2_ff <= sdi1_ff;
  end

  // data takes the same two stages as the link clock, so they stay aligned
  always_comb
  begin
    sclk_s = s2_ff[2];
    sclk_d = s3_ff[2];
    cs_n_s = s2_ff[1];
    cs_n_d = s3_ff[1];
    ld_n_s = s2_ff[0];
    sdi_s = sdi2_ff;
    sclk_rise = rising(sclk_s, sclk_d);
    cs_rise = rising(cs_n_s, cs_n_d);
  end

  // ************************************************************
  // serial shift register
  // ************************************************************

  logic [WORD_W-1:0] shift_ff, nxt_shift;

  // a short frame leaves older bits in place, a long one keeps the newest
  always_comb
  begin
    nxt_shift = shift_ff;
    if (sclk_rise && !cs_n_s)
    begin
      nxt_shift = {shift_ff[WORD_W-2:0], sdi_s};
    end
  end

  // no reset on the shift register, its contents start undefined
  always_ff @(posedge clock_in)
  begin
    shift_ff <= nxt_shift;
  end

  // ************************************************************
  // input register
  // ************************************************************

  logic [WORD_W-1:0] in_reg_ff, nxt_in_reg;
  logic taken_ff, nxt_taken;

  // loads only on the closing edge of a frame and holds in between
  always_comb
  begin
    nxt_in_reg = in_reg_ff;
    nxt_taken = 1'b0;
    if (cs_rise)
    begin
      nxt_in_reg = shift_ff;
      nxt_taken = 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      in_reg_ff <= MID_SCALE;
      taken_ff <= 1'b0;
    end
    else
    begin
      in_reg_ff <= nxt_in_reg;
      taken_ff <= nxt_taken;
    end
  end

  // ************************************************************
  // converter latch
  // ************************************************************

  logic [WORD_W-1:0] latch_ff, nxt_latch;

  // the strobe only acts with the frame closed, so a strobe that is low
  // during a frame cannot catch a half-shifted word
  always_comb
  begin
    nxt_latch = latch_ff;
    if (!ld_n_s && cs_n_s)
    begin
      // with the strobe tied low the new word goes straight through
      nxt_latch = cs_rise ? shift_ff : in_reg_ff;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      latch_ff <= MID_SCALE;
    end
    else
    begin
      latch_ff <= nxt_latch;
    end
  end

  // ************************************************************
  // switch decode
  // ************************************************************

  logic [SEG_N-1:0] seg_ff, nxt_seg;
  logic [LADDER_N-1:0] ladder_ff, nxt_ladder;

  // decoded from the next latch value, so the switches move on the same
  // edge as the latch and still come straight from flops
  always_comb
  begin
    nxt_seg = thermo(nxt_latch[WORD_W-1 -: SEG_BITS]);
    nxt_ladder = nxt_latch[LADDER_N-1:0];
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      seg_ff <= SEG_AT_RESET;
      ladder_ff <= MID_SCALE[LADDER_N-1:0];
    end
    else
    begin
      seg_ff <= nxt_seg;
      ladder_ff <= nxt_ladder;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************

  assign latch_word_out = latch_ff;
  assign segment_switch_controls_out = seg_ff;
  assign ladder_switch_controls_out = ladder_ff;
  assign word_taken_out = taken_ff;
endmodule // serial_latch_device
`default_nettype wire

// [hw/serial_latch_if.sv]
// Purpose: link wires between master and converter front end
// Assumes: all signals are plain single-driver wires
// Notes: no two-way pins on this link
`timescale 1ns/100ps
`default_nettype none
interface serial_latch_if;
  logic sclk;
  logic sdi;
  logic frame_sel_n;
  logic latch_load_n;
  modport master (output sclk, output sdi, output frame_sel_n, output latch_load_n);
  modport device (input sclk, input sdi, input frame_sel_n, input latch_load_n);
endinterface
`default_nettype wire

// [hw/serial_latch_master.sv]
// Purpose: bus master end, sends queued 16-bit words
// Assumes: serial clock made by dividing clock_in
// Notes: strobe mode selects pulsed load or permanently low
`timescale 1ns/100ps
`default_nettype none
module serial_latch_master
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // user words
  input wire logic word_valid_in,
  output logic word_ready_out,
  input wire logic [serial_latch_pkg::WORD_W-1:0] word_in,
  input wire logic load_tied_low_in,
  output logic busy_out,
  // link
  serial_latch_if.master link
);
  import serial_latch_pkg::*;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_LEAD = 3'b001, M_LOW = 3'b010, M_HIGH = 3'b011,
    M_GAP = 3'b100, M_LOAD = 3'b101, M_END = 3'b110
  } mstate_t;
  mstate_t st_ff, nxt_st;
  logic [WORD_W-1:0] sh_ff, nxt_sh;
  logic [CNT_W-1:0] bits_ff, nxt_bits;
  logic [TMR_W-1:0] tmr_ff, nxt_tmr;
  logic sclk_ff, nxt_sclk, cs_n_ff, nxt_cs_n, ld_n_ff, nxt_ld_n;
  logic f_valid, f_ready;
  logic [WORD_W-1:0] f_data;

  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in), .rst_in(rst_in),
    .in_valid_in(word_valid_in), .in_ready_out(word_ready_out), .in_data_in(word_in),
    .out_valid_out(f_valid), .out_ready_in(f_ready), .out_data_out(f_data)
  );

  always_comb
  begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bits = bits_ff;
    nxt_tmr = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
    nxt_sclk = sclk_ff;
    nxt_cs_n = cs_n_ff;
    nxt_ld_n = load_tied_low_in ? 1'b0 : 1'b1;
    f_ready = 1'b0;
    unique case (st_ff)
      M_IDLE:
      begin
        if (f_valid)
        begin
          f_ready = 1'b1;
          nxt_sh = f_data;
          nxt_bits = '0;
          nxt_cs_n = 1'b0;
          nxt_tmr = TMR_W'(SCLK_HALF_CYC - 1);
          nxt_st = M_LEAD;
        end
      end
      M_LEAD, M_HIGH:
      begin
        if (tmr_ff == '0)
        begin
          // the frame never closes early, so every word carries all its bits
          if (bits_ff == BITS_PER_WORD)
          begin
            nxt_cs_n = 1'b1;
            nxt_tmr = TMR_W'(LOAD_DELAY_CYC - 1);
            nxt_st = M_GAP;
          end
          else
          begin
            nxt_sclk = 1'b0;
            // data moves on the falling edge so it is stable at the rising one;
            // the first bit is already on the pin from the load in idle
            if (st_ff == M_HIGH)
            begin
              nxt_sh = {sh_ff[WORD_W-2:0], 1'b0};
            end
            nxt_tmr = TMR_W'(SCLK_HALF_CYC - 1);
            nxt_st = M_LOW;
          end
        end
      end
      M_LOW:
      begin
        if (tmr_ff == '0)
        begin
          nxt_sclk = 1'b1;
          nxt_bits = bits_ff + 1'b1;
          nxt_tmr = TMR_W'(SCLK_HALF_CYC - 1);
          nxt_st = M_HIGH;
        end
      end
      M_GAP:
      begin
        if (tmr_ff == '0)
        begin
          nxt_ld_n = 1'b0;
          nxt_tmr = TMR_W'(LOAD_WIDTH_CYC - 1);
          nxt_st = M_LOAD;
        end
      end
      M_LOAD:
      begin
        nxt_ld_n = 1'b0;
        if (tmr_ff == '0)
        begin
          nxt_ld_n = load_tied_low_in ? 1'b0 : 1'b1;
          nxt_tmr = TMR_W'(LOAD_DELAY_CYC - 1);
          nxt_st = M_END;
        end
      end
      M_END:
      begin
        if (tmr_ff == '0)
        begin
          nxt_st = M_IDLE;
        end
      end
      default:
      begin
        nxt_st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_ff <= M_IDLE;
      sh_ff <= '0;
      bits_ff <= '0;
      tmr_ff <= '0;
      sclk_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      ld_n_ff <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bits_ff <= nxt_bits;
      tmr_ff <= nxt_tmr;
      sclk_ff <= nxt_sclk;
      cs_n_ff <= nxt_cs_n;
      ld_n_ff <= nxt_ld_n;
    end
  end

  assign link.sclk = sclk_ff;
  assign link.sdi = sh_ff[WORD_W-1];
  assign link.frame_sel_n = cs_n_ff;
  assign link.latch_load_n = ld_n_ff;
  assign busy_out = st_ff != M_IDLE;
endmodule // serial_latch_master
`default_nettype wire

// [hw/serial_latch_pkg.sv]
// Purpose: shared constants for the serial converter input latch link
// Assumes: one 125 MHz system clock on both ends
// Notes: link clock is sampled, never used as a clock
package serial_latch_pkg;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int SEG_N = 15;
  localparam int SEG_BITS = 4;
  localparam int LADDER_N = 12;
  localparam logic [WORD_W-1:0] MID_SCALE = 16'h8000;
  localparam int CLK_PERIOD_NS = 8;
  // serial clock half period of the master, in ns, rounded up to system cycles
  localparam int SCLK_HALF_NS = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // select-high to load-strobe delay and strobe width
  localparam int LOAD_DELAY_NS = 30;
  localparam int LOAD_DELAY_CYC = (LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_WIDTH_NS = 30;
  localparam int LOAD_WIDTH_CYC = (LOAD_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
  localparam int FIFO_DEPTH = 4;
endpackage

// [hw/word_fifo.sv]
// Purpose: small word FIFO with valid/ready on both sides
// Assumes: single clock
// Notes: depth must be a power of two
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic push, pop;

  always_comb
  begin
    in_ready_out = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    out_valid_out = wr_ff != rd_ff;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
    out_data_out = mem_ff[rd_ff[AW-1:0]];
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  // storage carries no reset; only pointers define contents
  always_ff @(posedge clock_in)
  begin
    if (push)
    begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_in;
    end
  end
endmodule // word_fifo
`default_nettype wire

// [test/serial_latch_sva.sv]
// Purpose: link and output checks for the master and device pair
// Assumes: every link signal is sampled on clock_in
// Notes: instanced beside the link, no bind
`timescale 1ns/100ps
`default_nettype none
module serial_latch_sva
  import serial_latch_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // link
  input wire logic sclk,
  input wire logic sdi,
  input wire logic frame_sel_n,
  input wire logic latch_load_n,
  // end signals
  input wire logic load_tied_low_in,
  input wire logic word_taken_out,
  input wire logic [serial_latch_pkg::WORD_W-1:0] latch_word_out,
  input wire logic [serial_latch_pkg::SEG_N-1:0] segment_switch_controls_out,
  input wire logic [serial_latch_pkg::LADDER_N-1:0] ladder_switch_controls_out
);
  logic [4:0] rises_ff;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // ****
  // link clock rises in the open frame
  // ****
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      rises_ff <= 5'h00;
    else
      rises_ff <= frame_sel_n ? 5'h00 : rises_ff + 5'($rose(sclk));
  // ****
  // checks
  // ****
  a_idle_clock: assert property (frame_sel_n |-> sclk)
    else $error("link clock low outside frame");
  a_half_high: assert property ($rose(sclk) |-> sclk[*8])
    else $error("link clock high phase short");
  a_data_stable: assert property ($rose(sclk) |-> $stable(sdi))
    else $error("data moved at rising link clock");
  a_strobe_frame: assert property (!load_tied_low_in && !frame_sel_n |-> latch_load_n)
    else $error("load strobe low inside frame");
  a_strobe_width: assert property ($fell(latch_load_n) |-> !latch_load_n[*4])
    else $error("load strobe too short");
  a_sixteen_rises: assert property ($rose(frame_sel_n) |-> rises_ff == 5'h10)
    else $error("frame did not carry sixteen clocks");
  a_taken_after: assert property ($rose(frame_sel_n) |-> ##[2:5] word_taken_out)
    else $error("word not taken after frame end");
  a_taken_pulse: assert property (word_taken_out |=> !word_taken_out)
    else $error("word taken longer than one cycle");
  a_latch_quiet: assert property ($changed(latch_word_out) |-> frame_sel_n)
    else $error("latch moved inside frame");
  a_decode_ok: assert property ($stable(latch_word_out) |->
    segment_switch_controls_out == (15'h7fff >> (4'hf - latch_word_out[15:12]))
    && ladder_switch_controls_out == latch_word_out[11:0])
    else $error("switch decode wrong");
  c_frame: cover property ($rose(frame_sel_n));
  c_strobe: cover property ($fell(latch_load_n));
  c_tied: cover property (word_taken_out && load_tied_low_in);
endmodule // serial_latch_sva
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench for master and device joined by the link
// Assumes: words pushed from the user side, results read at the device
// Notes: each taken word is judged by one monitor
`timescale 1ns/100ps
`default_nettype none
module tb;
  import serial_latch_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic word_valid_in = 1'b0;
  logic load_tied_low_in = 1'b0;
  logic [WORD_W-1:0] word_in = 16'h0000;
  logic word_ready_out, busy_out, word_taken_out, refused;
  logic [WORD_W-1:0] latch_word_out, exp_w, prev_w;
  logic [SEG_N-1:0] segment_switch_controls_out;
  logic [LADDER_N-1:0] ladder_switch_controls_out;
  logic [WORD_W-1:0] exp_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  serial_latch_if link ();
  serial_latch_master i_serial_latch_master (.clock_in(clock_in), .rst_in(rst_in),
    .word_valid_in(word_valid_in), .word_ready_out(word_ready_out), .word_in(word_in),
    .load_tied_low_in(load_tied_low_in), .busy_out(busy_out), .link(link));
  serial_latch_device i_serial_latch_device (.clock_in(clock_in), .rst_in(rst_in),
    .link(link), .latch_word_out(latch_word_out), .word_taken_out(word_taken_out),
    .segment_switch_controls_out(segment_switch_controls_out),
    .ladder_switch_controls_out(ladder_switch_controls_out));
  serial_latch_sva i_serial_latch_sva (.clock_in(clock_in), .rst_in(rst_in),
    .sclk(link.sclk), .sdi(link.sdi), .frame_sel_n(link.frame_sel_n),
    .latch_load_n(link.latch_load_n), .load_tied_low_in(load_tied_low_in),
    .word_taken_out(word_taken_out), .latch_word_out(latch_word_out),
    .segment_switch_controls_out(segment_switch_controls_out),
    .ladder_switch_controls_out(ladder_switch_controls_out));
  always #(CLK_PERIOD_NS / 2) clock_in = ~clock_in;
  // ****
  // shared tasks
  // ****
  function automatic logic [WORD_W-1:0] therm(input logic [3:0] c);
    therm = 16'h0000;
    for (int i = 0; i < SEG_N; i++)
      therm[i] = (i < c);
  endfunction
  task automatic chk(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // valid stays up so back-to-back pushes never lower and raise it in one step
  task automatic push(input logic [WORD_W-1:0] w);
    word_valid_in <= 1'b1;
    word_in <= w;
    exp_q.push_back(w);
    @(negedge clock_in);
    while (word_ready_out !== 1'b1)
    begin
      refused = 1'b1;
      @(negedge clock_in);
    end
    @(posedge clock_in);
  endtask
  task automatic drain();
    word_valid_in <= 1'b0;
    for (int i = 0; i < 20000 && (exp_q.size() > 0 || busy_out !== 1'b0); i++)
      @(posedge clock_in);
    repeat (16) @(posedge clock_in);
    chk("pending words", 16'h0000, 16'(exp_q.size()));
    chk("master busy", 16'h0000, 16'(busy_out));
  endtask
  // ****
  // monitor: latch waits for the strobe unless tied low
  // ****
  always @(negedge clock_in)
    if (word_taken_out === 1'b1)
    begin
      exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
      if (load_tied_low_in)
        chk("tied latch", exp_w, latch_word_out);
      else
        chk("held latch", prev_w, latch_word_out);
      repeat (12) @(negedge clock_in);
      chk("latch", exp_w, latch_word_out);
      chk("segments", therm(exp_w[15:12]), 16'(segment_switch_controls_out));
      chk("ladder", 16'(exp_w[11:0]), 16'(ladder_switch_controls_out));
      prev_w = exp_w;
    end
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    chk("reset latch", MID_SCALE, latch_word_out);
    chk("reset segments", 16'h00ff, 16'(segment_switch_controls_out));
    chk("reset ladder", 16'h0000, 16'(ladder_switch_controls_out));
  endtask
  task automatic t_strobed();
    logic [WORD_W-1:0] ws[4] = '{16'h0000, 16'hffff, 16'h1234, 16'h8001};
    foreach (ws[i])
    begin
      push(ws[i]);
      drain();
    end
  endtask
  task automatic t_burst();
    logic [WORD_W-1:0] ws[6] = '{16'ha5a5, 16'h5a5a, 16'h0f0f, 16'hf0f0, 16'h7fff, 16'h0001};
    refused = 1'b0;
    foreach (ws[i])
      push(ws[i]);
    chk("fifo refused", 16'h0001, 16'(refused));
    drain();
  endtask
  task automatic t_tied();
    load_tied_low_in <= 1'b1;
    @(posedge clock_in);
    push(16'hc3c3);
    push(16'h3c3c);
    drain();
    load_tied_low_in <= 1'b0;
    @(posedge clock_in);
  endtask
  initial
  begin
    prev_w = MID_SCALE;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    t_reset();
    t_strobed();
    t_burst();
    t_tied();
    tally_and_finish();
  end
  // about 12 words of some 340 cycles each; six times that is allowed
  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
